// [src/alc_pkg.sv]
// Purpose: shared constants and types of the alarm channel block
// Assumes: 32-bit AHB-Lite register access, one 100 MHz clock
// Notes: display value, setpoints and hysteresis share one scaling
package alc_pkg;
	// ==========================================================
	// sizes
	localparam int DATA_W = 16;
	localparam int TMR_W = 12;
	localparam int NCH = 2;
	localparam int DIGITS = 4;
	localparam int EDIT_MAX = 9999;
	localparam int TIME_MAX_S = 3600;
	// ==========================================================
	// timing
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYC = CLK_HZ * TICK_S;
	localparam int TIMEOUT_S = 10;
	// ==========================================================
	// register map, byte addresses
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_SP = 8'h04;
	localparam logic [7:0] A_HYS = 8'h0C;
	localparam logic [7:0] A_DLY = 8'h14;
	localparam logic [7:0] A_SIL = 8'h1C;
	localparam logic [7:0] A_CODE = 8'h24;
	localparam logic [7:0] A_STAT = 8'h28;
	localparam logic [7:0] A_STRIDE = 8'h04;
	// control fields
	localparam int CTRL_ACC = 0;
	localparam int CTRL_EN = 1;
	localparam int CTRL_HI = 3;
	localparam int CTRL_NC = 5;
	// status fields
	localparam int ST_ACT = 0;
	localparam int ST_COND = 2;
	localparam int ST_MODE = 4;
	// reset values
	localparam logic CTRL_RST = 1'b0;
	localparam logic [15:0] CODE_RST = 16'h0000;
	// bus
	localparam int HT_ACTIVE = 1;
	localparam logic HRESP_OKAY = 1'b0;
	// ==========================================================
	// types
	typedef enum logic [2:0] {
		M_DISP = 3'b000,
		M_VIEW = 3'b001,
		M_CODE = 3'b010,
		M_CODE_ED = 3'b011,
		M_SP = 3'b100,
		M_SP_ED = 3'b101
	} alc_menu_t;
	typedef enum logic [1:0] {
		AL_IDLE = 2'b00,
		AL_DELAY = 2'b01,
		AL_ACTIVE = 2'b10,
		AL_SILENCE = 2'b11
	} alc_alarm_t;
endpackage

// [src/alc_chan_if.sv]
// Purpose: settings and state carried between control and one alarm
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ns
`default_nettype none
interface alc_chan_if
	import alc_pkg::*;
#(parameter int DW = DATA_W, parameter int TW = TMR_W);
	logic en;
	logic high;
	logic [DW-1:0] value;
	logic [DW-1:0] sp;
	logic [DW-1:0] hyst;
	logic [TW-1:0] dly;
	logic [TW-1:0] silence_duration;
	logic tick;
	logic ack;
	logic cond;
	alc_alarm_t state;
	modport ctl(output en, high, value, sp, hyst, dly, silence_duration, tick, ack, input cond, state);
	modport chan(input en, high, value, sp, hyst, dly, silence_duration, tick, ack, output cond, state);
endinterface
`default_nettype wire

// [src/alc_channel.sv]
// Purpose: one alarm: threshold with hysteresis, delay and silence
// Assumes: tick is a one-cycle pulse once a second
// Notes: state changes one cycle after the condition flop
`timescale 1ns/1ns
`default_nettype none
module alc_channel
	import alc_pkg::*;
#(parameter int DW = DATA_W, parameter int TW = TMR_W)
(
	input wire logic hclk,
	input wire logic hresetn,
	alc_chan_if.chan ch
);
	logic [DW:0] val_x;
	logic [DW:0] sp_x;
	logic [DW:0] hys_x;
	logic next_cond;
	logic [TW-1:0] cnt;
	// ==========================================================
	// threshold compare, all in display units
	assign val_x = {1'b0, ch.value};
	assign sp_x = {1'b0, ch.sp};
	assign hys_x = {1'b0, ch.hyst};
	always_comb begin
		if (!ch.en) begin
			next_cond = 1'b0;
		end else if (ch.high) begin
			next_cond = (val_x >= sp_x) || (ch.cond && (val_x + hys_x >= sp_x));
		end else begin
			next_cond = (val_x <= sp_x) || (ch.cond && (val_x <= sp_x + hys_x));
		end
	end
	// condition flop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch.cond <= 1'b0;
		end else begin
			ch.cond <= next_cond;
		end
	end
	// ==========================================================
	// delay and silence sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch.state <= AL_IDLE;
			cnt <= '0;
		end else if (!ch.en) begin
			ch.state <= AL_IDLE;
		end else begin
			case (ch.state)
				AL_IDLE: begin
					if (ch.cond && ch.dly == '0) begin
						ch.state <= AL_ACTIVE;
					end else if (ch.cond) begin
						ch.state <= AL_DELAY;
						cnt <= ch.dly;
					end
				end
				AL_DELAY: begin
					if (!ch.cond) begin
						ch.state <= AL_IDLE;
					end else if (ch.tick && cnt <= TW'(1)) begin
						ch.state <= AL_ACTIVE;
					end else if (ch.tick) begin
						cnt <= cnt - TW'(1);
					end
				end
				AL_ACTIVE: begin
					if (!ch.cond) begin
						ch.state <= AL_IDLE;
					end else if (ch.ack && ch.silence_duration != '0) begin
						ch.state <= AL_SILENCE;
						cnt <= ch.silence_duration;
					end
				end
				AL_SILENCE: begin
					if (ch.tick && cnt <= TW'(1)) begin
						ch.state <= ch.cond ? AL_ACTIVE : AL_IDLE;
					end else if (ch.tick) begin
						cnt <= cnt - TW'(1);
					end
				end
				default: begin
					ch.state <= AL_IDLE;
				end
			endcase
		end
	end
	// ==========================================================
	// checks
	property p_high_set;
		@(posedge hclk) disable iff (!hresetn)
		ch.en && ch.high && ch.value >= ch.sp |=> ch.cond;
	endproperty
	a_high_set: assert property (p_high_set) else $error("high alarm missed");
	property p_high_hold;
		@(posedge hclk) disable iff (!hresetn)
		ch.en && ch.high && ch.cond && val_x + hys_x >= sp_x |=> ch.cond;
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("hysteresis lost");
	property p_low_clear;
		@(posedge hclk) disable iff (!hresetn)
		ch.en && !ch.high && val_x > sp_x + hys_x |=> !ch.cond;
	endproperty
	a_low_clear: assert property (p_low_clear) else $error("low alarm stuck");
	property p_zero_delay;
		@(posedge hclk) disable iff (!hresetn)
		ch.en && ch.state == AL_IDLE && ch.cond && ch.dly == '0 |=> ch.state == AL_ACTIVE;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay late");
	sequence s_ack_active;
		ch.en && ch.state == AL_ACTIVE && ch.cond && ch.ack;
	endsequence
	property p_silence;
		@(posedge hclk) disable iff (!hresetn)
		s_ack_active ##0 ch.silence_duration != '0 |=> ch.state == AL_SILENCE;
	endproperty
	a_silence: assert property (p_silence) else $error("ack ignored");
	property p_no_silence;
		@(posedge hclk) disable iff (!hresetn)
		s_ack_active ##0 ch.silence_duration == '0 |=> ch.state == AL_ACTIVE;
	endproperty
	a_no_silence: assert property (p_no_silence) else $error("ack with zero silence");
endmodule
`default_nettype wire

// [src/alc_alarm_top.sv]
// Purpose: two alarm channels, operator setpoint menu, AHB-Lite registers
// Assumes: buttons synchronous and debounced, display_value in display units
// Notes: zero wait state slave, always OKAY
//
// Behaviour
// - output switch follows polarity: NO open when quiet, NC closed; alarm inverts
// - hysteresis kept in display units, added or subtracted directly
// - high alarm sets at value >= setpoint, clears below setpoint minus hysteresis
// - delay in whole seconds up to 3600; zero activates at once
// - annunciator flashes during delay, steady and output active after it
// - with nonzero silence, step in display mode acknowledges alarms
// - acknowledge returns active output to non-alarm for silence time
// - silence 0 to 3600 seconds, zero disables acknowledge
// - annunciator flashes during silence; alarm returns if condition holds
// - access enable gates setpoint adjustment from display mode
// - enter with up or down always shows setpoints read-only
// - direct access guarded by four digit code edited digit by digit
// - code zero means no protection, step plus up goes to setpoints
// - after reset access disabled and code zero
// - step plus up opens first setpoint, or code prompt when protected
// - correct code then enter shows first setpoint; up/down toggles setpoints
// - wrong code or ten idle seconds returns to display mode
// - edit flashes a digit, up/down change it, step moves, enter commits
// - after commit prompt shows again; enter at prompt returns to display
// - step plus up ignored while access enable is off
// - per alarm enable stops function, keeps parameters
// - each alarm independently high or low with its own parameters
`timescale 1ns/1ns
`default_nettype none
module alc_alarm_top
	import alc_pkg::*;
#(
	parameter int DW = DATA_W,
	parameter int TW = TMR_W,
	parameter int TICK_CYCLES = TICK_CYC
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [DW-1:0] display_value,
	input wire logic btn_step,
	input wire logic btn_enter,
	input wire logic btn_up,
	input wire logic btn_down,
	output logic [NCH-1:0] alarm_switch,
	output logic [NCH-1:0] annunciator,
	output alc_menu_t menu_mode,
	output logic menu_sel,
	output logic [DW-1:0] edit_value,
	output logic [1:0] edit_digit
);
	localparam int PW = $clog2(TICK_CYCLES + 1);
	localparam int IW = $clog2(TIMEOUT_S + 1);
	// ==========================================================
	// register state
	logic access_en;
	logic [NCH-1:0] al_en;
	logic [NCH-1:0] al_high;
	logic [NCH-1:0] al_nc;
	logic [DW-1:0] sp [NCH];
	logic [DW-1:0] hyst [NCH];
	logic [TW-1:0] dly [NCH];
	logic [TW-1:0] silence_duration [NCH];
	logic [DW-1:0] code;
	// bus phase state
	logic wr_pend;
	logic [7:0] wr_addr;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic take;
	// timing
	logic [PW-1:0] pre;
	logic tick;
	logic flash;
	logic [IW-1:0] idle;
	// buttons
	logic p_step;
	logic p_enter;
	logic p_up;
	logic p_down;
	logic any_press;
	logic combo_rise;
	logic view_rise;
	logic step_press;
	logic enter_press;
	logic up_press;
	logic down_press;
	logic ack;
	logic commit;
	logic [NCH-1:0] st_act;
	logic [NCH-1:0] st_cond;
	alc_chan_if #(.DW(DW), .TW(TW)) chx [NCH] ();
	// ==========================================================
	// helpers
	function automatic logic [DW-1:0] digit_weight(input logic [1:0] d);
		logic [DW-1:0] w;
		w = DW'(1);
		for (int k = 0; k < DIGITS; k++) begin
			if (k < d) begin
				w = DW'(w * DW'(10));
			end
		end
		return w;
	endfunction
	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
		return a == 8'(base + 8'(i) * A_STRIDE);
	endfunction
	// ==========================================================
	// AHB-Lite slave, zero wait
	assign take = hsel && hready && htrans[HT_ACTIVE];
	assign addr_ok = haddr[31:8] == '0;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
			hrdata <= '0;
			hreadyout <= 1'b0;
			hresp <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			wr_pend <= take && hwrite && addr_ok;
			wr_addr <= haddr[7:0];
			if (take && !hwrite) begin
				hrdata <= addr_ok ? rd_mux : '0;
			end
		end
	end
	// read mux, unmapped reads as zero
	always_comb begin
		rd_mux = '0;
		if (haddr[7:0] == A_CTRL) begin
			rd_mux[CTRL_ACC] = access_en;
			rd_mux[CTRL_EN +: NCH] = al_en;
			rd_mux[CTRL_HI +: NCH] = al_high;
			rd_mux[CTRL_NC +: NCH] = al_nc;
		end
		if (haddr[7:0] == A_CODE) begin
			rd_mux[DW-1:0] = code;
		end
		if (haddr[7:0] == A_STAT) begin
			rd_mux[ST_ACT +: NCH] = st_act;
			rd_mux[ST_COND +: NCH] = st_cond;
			rd_mux[ST_MODE +: 3] = menu_mode;
		end
		for (int i = 0; i < NCH; i++) begin
			if (hit(haddr[7:0], A_SP, i)) begin
				rd_mux[DW-1:0] = sp[i];
			end
			if (hit(haddr[7:0], A_HYS, i)) begin
				rd_mux[DW-1:0] = hyst[i];
			end
			if (hit(haddr[7:0], A_DLY, i)) begin
				rd_mux[TW-1:0] = dly[i];
			end
			if (hit(haddr[7:0], A_SIL, i)) begin
				rd_mux[TW-1:0] = silence_duration[i];
			end
		end
	end
	// shared control and code registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			access_en <= CTRL_RST;
			al_en <= '0;
			al_high <= '0;
			al_nc <= '0;
			code <= DW'(CODE_RST);
		end else if (wr_pend) begin
			if (wr_addr == A_CTRL) begin
				access_en <= hwdata[CTRL_ACC];
				al_en <= hwdata[CTRL_EN +: NCH];
				al_high <= hwdata[CTRL_HI +: NCH];
				al_nc <= hwdata[CTRL_NC +: NCH];
			end
			if (wr_addr == A_CODE) begin
				code <= hwdata[DW-1:0];
			end
		end
	end
	// ==========================================================
	// per alarm parameters and channels
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		// setpoint written by bus or by operator commit
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				sp[i] <= '0;
			end else if (wr_pend && hit(wr_addr, A_SP, i)) begin
				sp[i] <= hwdata[DW-1:0];
			end else if (commit && menu_sel == 1'(i)) begin
				sp[i] <= edit_value;
			end
		end
		// hysteresis, delay and silence
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				hyst[i] <= '0;
				dly[i] <= '0;
				silence_duration[i] <= '0;
			end else if (wr_pend) begin
				if (hit(wr_addr, A_HYS, i)) begin
					hyst[i] <= hwdata[DW-1:0];
				end
				if (hit(wr_addr, A_DLY, i) && hwdata[31:0] <= 32'(TIME_MAX_S)) begin
					dly[i] <= hwdata[TW-1:0];
				end
				if (hit(wr_addr, A_SIL, i) && hwdata[31:0] <= 32'(TIME_MAX_S)) begin
					silence_duration[i] <= hwdata[TW-1:0];
				end
			end
		end
		assign chx[i].en = al_en[i];
		assign chx[i].high = al_high[i];
		assign chx[i].value = display_value;
		assign chx[i].sp = sp[i];
		assign chx[i].hyst = hyst[i];
		assign chx[i].dly = dly[i];
		assign chx[i].silence_duration = silence_duration[i];
		assign chx[i].tick = tick;
		assign chx[i].ack = ack;
		assign st_act[i] = chx[i].state == AL_ACTIVE;
		assign st_cond[i] = chx[i].cond;
		alc_channel #(.DW(DW), .TW(TW)) u_ch (
			.hclk(hclk),
			.hresetn(hresetn),
			.ch(chx[i])
		);
		// switch and annunciator flops
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				alarm_switch[i] <= 1'b0;
				annunciator[i] <= 1'b0;
			end else begin
				alarm_switch[i] <= al_nc[i] ^ st_act[i];
				annunciator[i] <= st_act[i] || (chx[i].state != AL_IDLE && flash);
			end
		end
	end
	// ==========================================================
	// one second tick and flash phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre <= '0;
			tick <= 1'b0;
			flash <= 1'b0;
		end else begin
			tick <= pre == PW'(TICK_CYCLES - 1);
			pre <= pre == PW'(TICK_CYCLES - 1) ? '0 : pre + PW'(1);
			if (tick) begin
				flash <= !flash;
			end
		end
	end
	// ==========================================================
	// button edges and gestures
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			p_step <= 1'b0;
			p_enter <= 1'b0;
			p_up <= 1'b0;
			p_down <= 1'b0;
		end else begin
			p_step <= btn_step;
			p_enter <= btn_enter;
			p_up <= btn_up;
			p_down <= btn_down;
		end
	end
	assign combo_rise = btn_step && btn_up && !(p_step && p_up);
	assign view_rise = btn_enter && (btn_up || btn_down) && !(p_enter && (p_up || p_down));
	assign step_press = btn_step && !p_step && !btn_up;
	assign enter_press = btn_enter && !p_enter && !btn_up && !btn_down;
	assign up_press = btn_up && !p_up && !btn_step && !btn_enter;
	assign down_press = btn_down && !p_down && !btn_enter;
	assign any_press = (btn_step && !p_step) || (btn_enter && !p_enter)
		|| (btn_up && !p_up) || (btn_down && !p_down);
	// acknowledge while showing the process value
	assign ack = menu_mode == M_DISP && step_press;
	assign commit = menu_mode == M_SP_ED && enter_press && !step_press;
	// ==========================================================
	// inactivity timer inside the menus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle <= '0;
		end else if (menu_mode == M_DISP || any_press) begin
			idle <= '0;
		end else if (tick) begin
			idle <= idle + IW'(1);
		end
	end
	// ==========================================================
	// operator menu
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			menu_mode <= M_DISP;
			menu_sel <= 1'b0;
			edit_value <= '0;
			edit_digit <= '0;
		end else if (menu_mode != M_DISP && idle >= IW'(TIMEOUT_S)) begin
			menu_mode <= M_DISP;
		end else begin
			case (menu_mode)
				M_DISP: begin
					menu_sel <= 1'b0;
					if (combo_rise && access_en && code == '0) begin
						menu_mode <= M_SP;
					end else if (combo_rise && access_en) begin
						menu_mode <= M_CODE;
					end else if (view_rise) begin
						menu_mode <= M_VIEW;
					end
				end
				M_VIEW: begin
					if (up_press || down_press) begin
						menu_sel <= !menu_sel;
					end else if (enter_press) begin
						menu_mode <= M_DISP;
					end
				end
				M_CODE: begin
					if (step_press) begin
						menu_mode <= M_CODE_ED;
						edit_value <= '0;
						edit_digit <= 2'(DIGITS - 1);
					end
				end
				M_SP: begin
					if (up_press || down_press) begin
						menu_sel <= !menu_sel;
					end else if (step_press) begin
						menu_mode <= M_SP_ED;
						edit_value <= sp[menu_sel];
						edit_digit <= 2'(DIGITS - 1);
					end else if (enter_press) begin
						menu_mode <= M_DISP;
					end
				end
				M_CODE_ED, M_SP_ED: begin
					if (up_press && edit_value + digit_weight(edit_digit) <= DW'(EDIT_MAX)) begin
						edit_value <= edit_value + digit_weight(edit_digit);
					end else if (down_press && edit_value >= digit_weight(edit_digit)) begin
						edit_value <= edit_value - digit_weight(edit_digit);
					end else if (step_press) begin
						edit_digit <= edit_digit - 2'(1);
					end else if (enter_press && menu_mode == M_SP_ED) begin
						menu_mode <= M_SP;
					end else if (enter_press && edit_value == code) begin
						menu_mode <= M_SP;
						menu_sel <= 1'b0;
					end else if (enter_press) begin
						menu_mode <= M_DISP;
					end
				end
				default: begin
					menu_mode <= M_DISP;
				end
			endcase
		end
	end
	// ==========================================================
	// checks
	sequence s_gesture_off;
		menu_mode == M_DISP && combo_rise && !access_en;
	endsequence
	property p_gesture_off;
		@(posedge hclk) disable iff (!hresetn)
		s_gesture_off |=> menu_mode inside {M_DISP, M_VIEW};
	endproperty
	a_gesture_off: assert property (p_gesture_off) else $error("access taken while off");
	sequence s_gesture_on;
		menu_mode == M_DISP && combo_rise && access_en;
	endsequence
	property p_gesture_on;
		@(posedge hclk) disable iff (!hresetn)
		s_gesture_on |=> menu_mode == (code == '0 ? M_SP : M_CODE);
	endproperty
	a_gesture_on: assert property (p_gesture_on) else $error("wrong access prompt");
	property p_bad_code;
		@(posedge hclk) disable iff (!hresetn)
		menu_mode == M_CODE_ED && enter_press && edit_value != code
			&& idle < IW'(TIMEOUT_S) |=> menu_mode == M_DISP;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("wrong code accepted");
	property p_commit;
		@(posedge hclk) disable iff (!hresetn)
		commit && !wr_pend && idle < IW'(TIMEOUT_S)
			|=> menu_mode == M_SP && sp[$past(menu_sel)] == $past(edit_value);
	endproperty
	a_commit: assert property (p_commit) else $error("setpoint not committed");
	property p_polarity;
		@(posedge hclk) disable iff (!hresetn)
		##1 alarm_switch[0] == ($past(al_nc[0]) ^ $past(st_act[0]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("switch polarity wrong");
endmodule
`default_nettype wire

// [bench/alc_panel.sv]
// Purpose: front panel operator model driving the four buttons
// Assumes: button levels are clean and synchronous
// Notes: a press is one cycle high, then two cycles released
`timescale 1ns/1ns
`default_nettype none
module alc_panel (
	input wire logic hclk,
	output logic btn_step,
	output logic btn_enter,
	output logic btn_up,
	output logic btn_down
);
	// ==========================================================
	// idle panel
	initial begin
		{btn_step, btn_enter, btn_up, btn_down} = 4'h0;
	end
	// ==========================================================
	// one press, mask order step enter up down
	task automatic press(input logic [3:0] m);
		@(posedge hclk);
		{btn_step, btn_enter, btn_up, btn_down} <= m;
		@(posedge hclk);
		{btn_step, btn_enter, btn_up, btn_down} <= 4'h0;
		repeat (2) @(posedge hclk);
	endtask
endmodule
`default_nettype wire

// [bench/test_alarm_channel_with_setpoint_access.sv]
// Purpose: self-checking bench of the alarm block
// Assumes: one second shortened to 20 cycles
// Notes: checks queued by the driver, compared by a watcher
`timescale 1ns/1ns
`default_nettype none
module test_alarm_channel_with_setpoint_access;
	import alc_pkg::*;
	localparam int TK = 20;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, menu_sel;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, alarm_switch, annunciator, edit_digit;
	logic [15:0] display_value, edit_value, sp;
	logic btn_step, btn_enter, btn_up, btn_down;
	alc_menu_t menu_mode;
	int n_errors = 0, n_checks = 0, cyc = 0, seed = 9;
	typedef struct {int k; logic [31:0] e;} alc_note_t;
	alc_note_t q[$];
	event look;
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
	// ==========================================================
	// design and operator
	alc_alarm_top #(.TICK_CYCLES(TK)) dut_u (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hresp, .hrdata, .display_value, .btn_step, .btn_enter, .btn_up, .btn_down,
		.alarm_switch, .annunciator, .menu_mode, .menu_sel, .edit_value, .edit_digit);
	alc_panel pnl_u (.hclk, .btn_step, .btn_enter, .btn_up, .btn_down);
	// ==========================================================
	// clock and hang guard
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report();
		end
	end
	// ==========================================================
	// watcher: oldest note against the output it names
	always @(look) begin
		alc_note_t n;
		logic [31:0] g;
		n = q.pop_front();
		case (n.k)
			0: g = rd;
			1: g = {30'h0, alarm_switch};
			2: g = {29'h0, menu_mode};
			3: g = {30'h0, annunciator};
			4: g = {16'h0, edit_value};
			6: g = {30'h0, edit_digit};
			7: g = {31'h0, hresp};
			default: g = {31'h0, menu_sel};
		endcase
		`CK(g, n.e)
	end
	// ==========================================================
	// tasks
	task automatic ex(input int k, input logic [31:0] e);
		repeat (3) @(negedge hclk);
		q.push_back('{k, e});
		->look;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		hsize <= 3'h2;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic val(input logic [15:0] v);
		@(posedge hclk);
		display_value <= v;
		repeat (5) @(posedge hclk);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		hsize = 3'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		display_value = 16'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		sp = 16'h0100 + 16'($random(seed) & 8'hFF);
		bus(0, A_CTRL, 0); ex(0, 0); ex(7, 0);
		bus(0, A_CODE, 0); ex(0, 0);
		bus(0, 8'h40, 0); ex(0, 0);
		$display("done: reset");
		bus(1, A_SP, 32'(sp));
		bus(1, A_HYS, 32'hA);
		bus(1, A_CTRL, 32'h0A);
		val(sp); ex(1, 1);
		val(sp - 16'h5); ex(1, 1);
		val(sp - 16'hB); ex(1, 0);
		bus(1, A_CTRL, 32'h2A); ex(1, 1);
		val(sp); ex(1, 0);
		bus(1, A_CTRL, 32'h02); ex(1, 1);
		val(sp + 16'h5); ex(1, 1);
		val(sp + 16'hB); ex(1, 0);
		$display("done: threshold");
		bus(1, A_DLY, 32'h2);
		bus(1, A_CTRL, 32'h0A); ex(1, 0);
		repeat (3 * TK + 10) @(posedge hclk);
		ex(1, 1); ex(3, 1);
		ex(3, 1);
		$display("done: delay");
		bus(1, A_DLY, 0);
		bus(1, A_SIL, 32'h2);
		pnl_u.press(4'h8); ex(1, 0);
		repeat (3 * TK + 10) @(posedge hclk);
		ex(1, 1);
		bus(1, A_SIL, 0);
		pnl_u.press(4'h8); ex(1, 1);
		$display("done: silence");
		val(sp - 16'hB);
		pnl_u.press(4'hA); ex(2, 0);
		pnl_u.press(4'h6); ex(2, 1);
		pnl_u.press(4'h4); ex(2, 0);
		bus(1, A_CTRL, 32'h0B);
		pnl_u.press(4'hA); ex(2, 4);
		pnl_u.press(4'h8); ex(2, 5); ex(4, 32'(sp));
		pnl_u.press(4'h2); ex(4, 32'(sp + 16'h03E8));
		pnl_u.press(4'h8); ex(6, 2);
		pnl_u.press(4'h4); ex(2, 4);
		bus(0, A_SP, 0); ex(0, 32'(sp + 16'h03E8));
		pnl_u.press(4'h4); ex(2, 0);
		$display("done: setpoint edit");
		bus(1, A_CODE, 32'h03E8);
		pnl_u.press(4'hA); ex(2, 2);
		pnl_u.press(4'h8); ex(2, 3); ex(6, 3);
		pnl_u.press(4'h2); ex(4, 32'h03E8);
		pnl_u.press(4'h4); ex(2, 4);
		pnl_u.press(4'h2); ex(5, 1);
		repeat (12 * TK) @(posedge hclk);
		ex(2, 0);
		pnl_u.press(4'hA);
		pnl_u.press(4'h8); ex(2, 3);
		pnl_u.press(4'h4); ex(2, 0);
		$display("done: code");
		final_report();
	end
endmodule
`default_nettype wire
